// >>> logic/sbs_status_byte.sv
// status byte, service request enable and the two message queues
// assumes command strobes are one-cycle pulses on clk from the parser
`timescale 1ns/1ns
`default_nettype none
module sbs_status_byte (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire sbs_pkg::sbs_msg_s resp_in,
  output logic               resp_ready,
  input  wire logic          resp_pop,
  output logic [7:0]         resp_data,
  output logic               resp_valid,
  input  wire sbs_pkg::sbs_msg_s err_in,
  input  wire logic          err_pop,
  output logic [7:0]         err_data,
  output logic               err_valid,
  output logic               err_dropped,
  input  wire logic          event_summary,
  input  wire logic          operation_summary,
  input  wire logic          clear_status,
  input  wire logic          mask_write,
  input  wire logic [7:0]    mask_wdata,
  output logic [7:0]         service_request_mask,
  input  wire logic          status_query,
  input  wire logic          serial_poll,
  output logic [7:0]         status_out,
  output logic               status_out_valid,
  output logic               srq
);
  // queue storage
  logic [7:0]                   oq_mem [sbs_pkg::OQ_DEPTH];
  logic [7:0]                   eq_mem [sbs_pkg::EQ_DEPTH];

  // per entry write enables
  logic [sbs_pkg::OQ_DEPTH-1:0] oq_we;
  logic [sbs_pkg::EQ_DEPTH-1:0] eq_we;

  // output queue pointers and level
  logic [sbs_pkg::OQ_PTR_W-1:0] oq_wr;
  logic [sbs_pkg::OQ_PTR_W-1:0] oq_rd;
  logic [sbs_pkg::OQ_CNT_W-1:0] oq_cnt;

  // output queue next values and flags
  logic [sbs_pkg::OQ_PTR_W-1:0] next_oq_wr;
  logic [sbs_pkg::OQ_PTR_W-1:0] next_oq_rd;
  logic [sbs_pkg::OQ_CNT_W-1:0] next_oq_cnt;
  logic                         oq_full;
  logic                         oq_empty;
  logic                         oq_push;
  logic                         oq_take;

  // error queue pointers and level
  logic [sbs_pkg::EQ_PTR_W-1:0] eq_wr;
  logic [sbs_pkg::EQ_PTR_W-1:0] eq_rd;
  logic [sbs_pkg::EQ_CNT_W-1:0] eq_cnt;

  // error queue next values
  logic [sbs_pkg::EQ_PTR_W-1:0] eq_waddr;
  logic [sbs_pkg::EQ_PTR_W-1:0] eq_wr_inc;
  logic [sbs_pkg::EQ_PTR_W-1:0] eq_rd_base;
  logic [sbs_pkg::EQ_PTR_W-1:0] eq_rd_inc;
  logic [sbs_pkg::EQ_CNT_W-1:0] eq_cnt_base;
  logic [sbs_pkg::EQ_PTR_W-1:0] next_eq_wr;
  logic [sbs_pkg::EQ_PTR_W-1:0] next_eq_rd;
  logic [sbs_pkg::EQ_CNT_W-1:0] next_eq_cnt;

  // error queue flags
  logic                         eq_full;
  logic                         eq_empty;
  logic                         eq_push;
  logic                         eq_take;
  logic                         next_err_dropped;

  // status byte sources
  logic                         message_available_flag;
  logic                         error_available_flag;
  logic                         questionable_summary_bit;
  logic                         event_summary_bit;
  logic [7:0]                   summary;

  // enable mask and request logic
  logic [7:0]                   enabled_now;
  logic [7:0]                   enabled_prev;
  logic [7:0]                   next_enabled_prev;
  logic [7:0]                   rise_bits;
  logic                         rise;
  logic                         master_summary_bit;
  logic                         request_for_service_flag;
  logic                         next_request_for_service_flag;
  logic [7:0]                   next_service_request_mask;

  // status readout
  logic [7:0]                   query_byte;
  logic [7:0]                   poll_byte;
  logic [7:0]                   next_status_out;
  logic                         next_status_out_valid;

  // output queue handshakes
  assign oq_full    = oq_cnt == sbs_pkg::OQ_CNT_W'(sbs_pkg::OQ_DEPTH);
  assign oq_empty   = oq_cnt == '0;

  assign resp_ready = !oq_full;
  assign resp_valid = !oq_empty;

  assign oq_push    = resp_in.valid && !oq_full;
  assign oq_take    = resp_pop && !oq_empty;

  assign resp_data  = oq_mem[oq_rd];

  // output queue pointer updates, natural wrap at sixteen
  assign next_oq_wr  = oq_push ? oq_wr + 1'b1 : oq_wr;
  assign next_oq_rd  = oq_take ? oq_rd + 1'b1 : oq_rd;

  assign next_oq_cnt = oq_cnt + sbs_pkg::OQ_CNT_W'(oq_push)
                       - sbs_pkg::OQ_CNT_W'(oq_take);

  // error queue handshakes; a new message beats clear status
  assign eq_full   = eq_cnt == sbs_pkg::EQ_CNT_W'(sbs_pkg::EQ_DEPTH);
  assign eq_empty  = eq_cnt == '0;

  assign err_valid = !eq_empty;

  assign eq_push   = err_in.valid
                     && (clear_status || !eq_full);
  assign eq_take   = err_pop && !eq_empty
                     && !clear_status;

  assign err_data  = eq_mem[eq_rd];

  // error queue pointer updates, wrap after ten entries
  assign eq_waddr    = clear_status ? '0 : eq_wr;

  assign eq_wr_inc   = (eq_waddr == sbs_pkg::EQ_LAST) ? '0
                       : eq_waddr + 1'b1;
  assign next_eq_wr  = eq_push ? eq_wr_inc : eq_waddr;

  assign eq_rd_base  = clear_status ? '0 : eq_rd;
  assign eq_rd_inc   = (eq_rd == sbs_pkg::EQ_LAST) ? '0
                       : eq_rd + 1'b1;
  assign next_eq_rd  = eq_take ? eq_rd_inc : eq_rd_base;

  assign eq_cnt_base = clear_status ? '0 : eq_cnt;
  assign next_eq_cnt = eq_cnt_base + sbs_pkg::EQ_CNT_W'(eq_push)
                       - sbs_pkg::EQ_CNT_W'(eq_take);

  assign next_err_dropped = err_in.valid && !eq_push;

  // summary bits follow their sources
  assign message_available_flag   = !oq_empty;
  assign error_available_flag     = !eq_empty;
  assign questionable_summary_bit = 1'b0;
  assign event_summary_bit        = event_summary;

  always_comb begin
    summary                   = 8'h00;
    summary[sbs_pkg::BIT_EAV] = error_available_flag;
    summary[sbs_pkg::BIT_QSB] = questionable_summary_bit;
    summary[sbs_pkg::BIT_MAV] = message_available_flag;
    summary[sbs_pkg::BIT_ESB] = event_summary_bit;
    summary[sbs_pkg::BIT_OSB] = operation_summary;
  end

  // per bit enable and rising edge of the enabled summary
  for (genvar b = 0; b < sbs_pkg::DATA_W; b++) begin : g_bit
    assign enabled_now[b] = summary[b] & service_request_mask[b]
                            & sbs_pkg::SUM_MASK[b];
    assign rise_bits[b]   = enabled_now[b] & ~enabled_prev[b];
  end

  assign master_summary_bit = |enabled_now;
  assign rise               = |rise_bits;
  assign srq                = request_for_service_flag;

  // next values of the control registers
  assign next_service_request_mask = mask_write ? mask_wdata
                                     : service_request_mask;

  assign next_request_for_service_flag =
    rise ? 1'b1
    : (serial_poll || clear_status) ? 1'b0
    : request_for_service_flag;

  assign next_enabled_prev = enabled_now;

  assign query_byte = summary | {1'b0, master_summary_bit, 6'h00};

  assign poll_byte  = summary
                      | {1'b0, request_for_service_flag, 6'h00};

  assign next_status_out = status_query ? query_byte
                           : serial_poll ? poll_byte
                           : status_out;

  assign next_status_out_valid = status_query || serial_poll;

  // per entry write enables of the queue memories
  for (genvar i = 0; i < sbs_pkg::OQ_DEPTH; i++) begin : g_oq_mem
    assign oq_we[i] = oq_push
                      && oq_wr == sbs_pkg::OQ_PTR_W'(i);
    always_ff @(posedge clk) begin
      if (oq_we[i]) begin
        oq_mem[i] <= resp_in.data;
      end
    end
  end

  for (genvar i = 0; i < sbs_pkg::EQ_DEPTH; i++) begin : g_eq_mem
    assign eq_we[i] = eq_push
                      && eq_waddr == sbs_pkg::EQ_PTR_W'(i);
    always_ff @(posedge clk) begin
      if (eq_we[i]) begin
        eq_mem[i] <= err_in.data;
      end
    end
  end

  // output queue registers

  // output queue write pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oq_wr <= '0;
    end
    else begin
      oq_wr <= next_oq_wr;
    end
  end

  // output queue read pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oq_rd <= '0;
    end
    else begin
      oq_rd <= next_oq_rd;
    end
  end

  // output queue level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oq_cnt <= '0;
    end
    else begin
      oq_cnt <= next_oq_cnt;
    end
  end

  // error queue registers

  // error queue write pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eq_wr <= '0;
    end
    else begin
      eq_wr <= next_eq_wr;
    end
  end

  // error queue read pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eq_rd <= '0;
    end
    else begin
      eq_rd <= next_eq_rd;
    end
  end

  // error queue level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eq_cnt <= '0;
    end
    else begin
      eq_cnt <= next_eq_cnt;
    end
  end

  // dropped message pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_dropped <= 1'b0;
    end
    else begin
      err_dropped <= next_err_dropped;
    end
  end

  // service request registers

  // service request enable mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      service_request_mask <= sbs_pkg::MASK_RESET;
    end
    else begin
      service_request_mask <= next_service_request_mask;
    end
  end

  // enabled summary of the previous cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enabled_prev <= 8'h00;
    end
    else begin
      enabled_prev <= next_enabled_prev;
    end
  end

  // request for service flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      request_for_service_flag <= 1'b0;
    end
    else begin
      request_for_service_flag <= next_request_for_service_flag;
    end
  end

  // readout registers

  // status byte as last read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_out <= 8'h00;
    end
    else begin
      status_out <= next_status_out;
    end
  end

  // readout strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_out_valid <= 1'b0;
    end
    else begin
      status_out_valid <= next_status_out_valid;
    end
  end
endmodule : sbs_status_byte
`default_nettype wire

// >>> logic/sbs_pkg.sv
// package for the status byte and service request block
// assumes a single 250 MHz clock and command strobes from the parser
// Notes on behaviour
// - questionable summary bit always reads zero
// - two fifo queues: responses and errors
// - response written sets message available flag
// - read pops response; empty clears message flag
// - error queue holds ten; one per event
// - error entering queue sets error available flag
// - read pops error; empty clears error flag
// - summary bits follow their sources, no latch
// - event register read clears event summary bit
// - bit six: summary on query, request on poll
// - status query changes no status bits
// - serial poll clears request flag; may re-raise
// - poll leaves master summary; follows enabled bits
// - reset or clear status clears error and request bits; a new error or an enabled rise in the same cycle outlasts clear status
// - master summary is or of masked bits
// - mask written by command, read unchanged
// - mask clears on reset or zero write
// - enabled bit rising sets request and srq
package sbs_pkg;
  localparam int          DATA_W      = 8;
  localparam int          OQ_DEPTH    = 16;
  localparam int          EQ_DEPTH    = 10;
  localparam int          OQ_PTR_W    = 4;
  localparam int          EQ_PTR_W    = 4;
  localparam int          OQ_CNT_W    = 5;
  localparam int          EQ_CNT_W    = 4;
  localparam int          BIT_QSB     = 3;
  localparam int          BIT_MAV     = 4;
  localparam int          BIT_ESB     = 5;
  localparam int          BIT_RQS     = 6;
  localparam int          BIT_OSB     = 7;
  localparam int          BIT_EAV     = 2;
  localparam logic [7:0]  SUM_MASK    = 8'hbc;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  localparam logic [3:0]  EQ_LAST     = 4'h9;
  localparam logic [3:0]  OQ_LAST     = 4'hf;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sbs_msg_s;
endpackage : sbs_pkg

// >>> tb/sbs_chk.sv
// port checker for the status byte block
// assumes a bind into sbs_status_byte
`timescale 1ns/1ns
`default_nettype none
module sbs_chk (
  input wire logic       clk, rst, resp_valid, event_summary,
  input wire logic       err_valid, operation_summary, clear_status,
  input wire logic       status_query, serial_poll, srq,
  input wire logic [7:0] service_request_mask, status_out
);
  logic [7:0] cur, prev;
  wire        rise = |(cur & ~prev);
  assign cur = service_request_mask & {operation_summary, 1'b0,
    event_summary, resp_valid, 1'b0, err_valid, 2'b00};
  always_ff @(posedge clk or posedge rst)
    if (rst) prev <= 8'h00;
    else prev <= cur;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd; status_query || serial_poll; endsequence
  qsb_zero_a: assert property (s_rd |=> !status_out[3])
    else $error("bit 3 set");
  mav_copy_a: assert property (s_rd |=> status_out[4] == $past(resp_valid))
    else $error("bit 4 wrong");
  esb_copy_a: assert property (s_rd |=> status_out[5] == $past(event_summary))
    else $error("bit 5 wrong");
  mss_query_a: assert property (status_query |=> status_out[6] == $past(|cur))
    else $error("query bit 6 wrong");
  rqs_poll_a: assert property (serial_poll |=> status_out[6] == $past(srq))
    else $error("poll bit 6 wrong");
  srq_rise_a: assert property (rise && !clear_status |=> srq)
    else $error("srq not raised");
  poll_clear_a: assert property (serial_poll && !rise |=> !srq)
    else $error("poll kept srq");
  cls_clear_a: assert property (clear_status && !rise |=> !srq)
    else $error("clear kept srq");
endmodule : sbs_chk
`default_nettype wire

// >>> tb/sbs_host.sv
// bus controller model: status reads, polls, queue reads
// assumes strobes are taken on the rising edge of clk
`timescale 1ns/1ns
`default_nettype none
module sbs_host (
  input  wire logic clk,
  output logic      status_query, serial_poll, resp_pop, err_pop
);
  logic [3:0] c_q = 4'h0;
  assign {err_pop, resp_pop, serial_poll, status_query} = c_q;
  task automatic cmd(input logic [3:0] c);
    @(posedge clk) c_q <= c;
    @(posedge clk) c_q <= 4'h0;
    #1;
  endtask : cmd
endmodule : sbs_host
`default_nettype wire

// >>> tb/test_sbs_status_byte.sv
// bench for the status byte block against a queue model
// assumes sbs_host makes the controller strobes
`timescale 1ns/1ns
`default_nettype none
module test_sbs_status_byte;
  logic clk = 1'b0, rst = 1'b1, event_summary = 1'b0, srq;
  logic operation_summary = 1'b0, clear_status = 1'b0, err_dropped;
  logic mask_write = 1'b0, resp_ready, resp_valid, err_valid;
  logic status_out_valid, status_query, serial_poll, resp_pop, err_pop;
  logic [7:0] mask_wdata = 8'h00, resp_data, err_data, status_out;
  logic [7:0] service_request_mask, r = 8'h51;
  sbs_pkg::sbs_msg_s resp_in = '0, err_in = '0;
  int fails = 0, n_tests = 0, drops = 0, eq[$], oq[$];
  sbs_status_byte DUT (.*);
  sbs_host host (.*);
  always #2 clk = ~clk;
  always @(posedge clk) drops += int'(err_dropped === 1'b1);
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic [7:0] stb(input logic m);
    return {operation_summary, m, event_summary, oq.size() > 0, 1'b0,
      eq.size() > 0, 2'b00};
  endfunction : stb
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wmask(input logic [7:0] v);
    @(posedge clk) mask_write <= 1'b1;
    mask_wdata <= v;
    @(posedge clk) mask_write <= 1'b0;
  endtask : wmask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    host.cmd(4'h1);
    chk(status_out, 8'h00);
    chk(service_request_mask, 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk) err_in <= '{1'b1, r};
      if (i < 10) eq.push_back(r);
      r = lfsr(r);
      resp_in <= '{i < 3, r};
      if (i < 3) oq.push_back(r);
    end
    @(posedge clk) err_in <= '0;
    resp_in <= '0;
    host.cmd(4'h1);
    chk(status_out, stb(1'b0));
    chk(8'(drops), 8'h02);
    while (eq.size() > 0) begin
      chk(err_data, 8'(eq.pop_front()));
      host.cmd(4'h8);
    end
    while (oq.size() > 0) begin
      chk(resp_data, 8'(oq.pop_front()));
      host.cmd(4'h4);
    end
    chk({6'h00, err_valid, resp_valid}, 8'h00);
    wmask(8'h20);
    event_summary <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, srq}, 8'h01);
    chk(service_request_mask, 8'h20);
    host.cmd(4'h2);
    chk(status_out, stb(1'b1));
    chk({7'h00, srq}, 8'h00);
    host.cmd(4'h1);
    chk(status_out, stb(1'b1));
    wmask(8'h00);
    host.cmd(4'h1);
    chk(status_out, stb(1'b0));
    wmask(8'h80);
    operation_summary <= 1'b1;
    host.cmd(4'h1);
    chk(status_out, stb(1'b1));
    @(posedge clk) clear_status <= 1'b1;
    @(posedge clk) clear_status <= 1'b0;
    #1 chk({7'h00, srq}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      wmask(r);
      event_summary     <= r[0];
      operation_summary <= r[1];
      host.cmd(4'h1);
      chk(service_request_mask, r);
      chk(status_out, stb(|(stb(1'b0) & r & 8'hbc)));
    end
    @(posedge clk) err_in <= '{1'b1, r};
    clear_status <= 1'b1;
    @(posedge clk) err_in <= '0;
    clear_status <= 1'b0;
    #1 chk(err_data, r);
    chk({7'h00, err_valid}, 8'h01);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.cmd(4'h1);
    chk(service_request_mask, 8'h00);
    chk({7'h00, srq}, 8'h00);
    chk(status_out, stb(1'b0));
    tally_and_finish();
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule : test_sbs_status_byte
bind sbs_status_byte sbs_chk chk (.*);
`default_nettype wire
